/* File: common/brc_pkg.sv */
package brc_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets, AXI4-Lite)
    // ------------------------------------------------------------
    localparam logic [7:0] BRC_OFS_CTRL = 8'h00;    // Map select, reset enable
    localparam logic [7:0] BRC_OFS_STATUS = 8'h04;  // Live levels, read only
    localparam logic [7:0] BRC_OFS_IRQ_STAT = 8'h08; // Sticky events, W1C
    localparam logic [7:0] BRC_OFS_IRQ_MASK = 8'h0C; // Interrupt enables
    localparam logic [7:0] BRC_OFS_WAKE_EN = 8'h10; // Wake enable per level input
    localparam logic [7:0] BRC_OFS_BOOTCFG = 8'h14; // Boot bus setup, read only

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int BRC_CTRL_MAP_LSB = 0;      // Two-bit vector map select
    localparam int BRC_CTRL_RSTEN_BIT = 2;    // Brownout reset enable
    localparam int BRC_EV_WARN_BIT = 0;       // Supply warning event
    localparam int BRC_EV_WAKE_BIT = 1;       // Wake event

    // ------------------------------------------------------------
    // Boot and memory constants
    // ------------------------------------------------------------
    localparam logic [31:0] BRC_BOOT_ADDR = 32'h8100_0000; // Bank 1 base
    localparam logic [31:0] BRC_BOOTROM_BASE = 32'h7FFF_E000;
    localparam logic [31:0] BRC_SRAM_BASE = 32'h4000_0000;
    localparam logic [31:0] BRC_VEC_SIZE = 32'h0000_0040; // Vector window
    localparam logic [5:0] BRC_BOOT_DWIDTH = 6'h10;       // 16 data lines
    localparam logic [5:0] BRC_BOOT_AWIDTH = 6'h18;       // 24 address lines

    // Vector map selections
    typedef enum logic [1:0] {
        BRC_MAP_BOOTROM = 2'h0,
        BRC_MAP_SRAM = 2'h1,
        BRC_MAP_EXTMEM = 2'h2
    } brc_map_t;

    localparam logic [1:0] BRC_MAP_RESET = 2'h2; // External memory after reset

    // Reset stretch timing
    localparam int BRC_CLK_MHZ = 200;
    localparam int BRC_RST_HOLD_NS = 100;
    localparam int BRC_RST_HOLD_CYC = (BRC_RST_HOLD_NS * BRC_CLK_MHZ + 999) / 1000;

endpackage

/* File: hw/brc_reset_comb.sv */
`timescale 1ns/1ps

// Reset combiner with stretch counter
module brc_reset_comb
    import brc_pkg::*;
#(
    parameter int HOLD_CYC = BRC_RST_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pin_rst_n,
    input wire logic wdt_rst,
    input wire logic por,
    input wire logic sdm_rst,
    input wire logic osc_ok,
    output logic core_rst
);

    // ------------------------------------------------------------
    // Combining and stretching
    // ------------------------------------------------------------
    logic any_src; // Any of four sources active
    logic [15:0] cnt; // Clocks since all clear

    assign any_src = !pin_rst_n || wdt_rst || por || sdm_rst;

    // Count only while pin released and oscillator running
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 16'h0000;
            core_rst <= 1'b1;
        end else if (ce) begin
            if (any_src || !osc_ok) begin
                cnt <= 16'h0000;
                core_rst <= 1'b1;
            end else if (cnt < 16'(HOLD_CYC)) begin
                cnt <= cnt + 16'h0001;
                core_rst <= 1'b1;
            end else begin
                core_rst <= 1'b0;
            end
        end
    end

    a_rst_held: assert property (@(posedge clk) disable iff (rst)
        (ce && any_src) |=> core_rst)
        else $error("reset released while a source active");

endmodule

/* File: hw/brc_top.sv */
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Function
// - Fetch starts at bank 1 base address.
// - Boot bus: 16 data, 24 address lines.
// - Vector window hits external boot memory after reset.
// - Map select: boot ROM, SRAM, external.
// - Supply warning raises brownout interrupt request.
// - Interrupt gated by enable; level readable.
// - Low supply resets chip when enabled.
// - Brownout reset holds while supply low.
// - 68 edge plus four level inputs.
// - Level inputs can wake Power-down.
// - Reset held until pin, oscillator, count.
// - Four reset sources combined.
module brc_top
    import brc_pkg::*;
#(
    parameter int N_EDGE = 68,
    parameter int N_LEVEL = 4,
    parameter int HOLD_CYC = BRC_RST_HOLD_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // Reset sources
    input wire logic RESET_PIN_N,
    input wire logic WDT_RST,
    input wire logic POR,
    input wire logic OSC_OK,
    // Supply comparators
    input wire logic SUPPLY_WARN,
    input wire logic SUPPLY_LOW,
    // Interrupt inputs
    input wire logic [N_EDGE-1:0] EDGE_IRQ_IN,
    input wire logic [N_LEVEL-1:0] LEVEL_IRQ_IN,
    input wire logic POWER_DOWN,
    // CPU address translation for vector window
    input wire logic [31:0] CPU_ADDR,
    output logic [31:0] MAPPED_ADDR,
    // Boot, reset, interrupt and wake outputs
    output logic [31:0] BOOT_FETCH_ADDR,
    output logic [5:0] EXT_MEM_DATA_WIDTH,
    output logic [5:0] EXT_MEM_ADDR_WIDTH,
    output logic CHIP_RST,
    output logic SDM_IRQ,
    output logic [N_EDGE-1:0] EDGE_EVENT,
    output logic [N_LEVEL-1:0] LEVEL_IRQ,
    output logic WAKEUP,
    output logic IRQ,
    // AXI4-Lite slave
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Word offset match, ignoring byte lane bits
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    // Is the offset one of ours
    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, BRC_OFS_CTRL) || hit(a, BRC_OFS_STATUS) ||
            hit(a, BRC_OFS_IRQ_STAT) || hit(a, BRC_OFS_IRQ_MASK) ||
            hit(a, BRC_OFS_WAKE_EN) || hit(a, BRC_OFS_BOOTCFG);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    brc_map_t map_sel; // Vector map selection
    logic sdm_rst_en; // Brownout reset enable
    logic [1:0] irq_stat; // Sticky events
    logic [1:0] irq_mask; // Event enables
    logic [N_LEVEL-1:0] wake_en; // Wake enables
    logic [N_EDGE-1:0] edge_prev; // Previous edge input level
    logic warn_prev; // Previous warning level
    logic sdm_rst; // Brownout reset request
    logic sys_rst; // Combined internal reset
    logic wake_hit; // Enabled wake input active
    logic [1:0] events; // This cycle's events

    // ------------------------------------------------------------
    // Bus write channel state
    // ------------------------------------------------------------
    logic aw_held; // Address captured
    logic w_held; // Data captured
    logic [7:0] aw_addr; // Captured address
    logic [31:0] w_data; // Captured data
    logic [3:0] w_strb; // Captured strobes
    logic wr_go; // Commit a write this cycle

    // ------------------------------------------------------------
    // Reset combiner
    // ------------------------------------------------------------
    // Second stage only resets when enabled; held while supply stays low
    assign sdm_rst = SUPPLY_LOW && sdm_rst_en;

    brc_reset_comb #(
        .HOLD_CYC(HOLD_CYC)
    ) u_rst (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .pin_rst_n(RESET_PIN_N),
        .wdt_rst(WDT_RST),
        .por(POR),
        .sdm_rst(sdm_rst),
        .osc_ok(OSC_OK),
        .core_rst(sys_rst)
    );

    assign CHIP_RST = sys_rst;

    // ------------------------------------------------------------
    // Boot setup
    // ------------------------------------------------------------
    // Fixed values, held in flip-flops so they are clean from reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            BOOT_FETCH_ADDR <= BRC_BOOT_ADDR;
            EXT_MEM_DATA_WIDTH <= BRC_BOOT_DWIDTH;
            EXT_MEM_ADDR_WIDTH <= BRC_BOOT_AWIDTH;
        end else if (CE) begin
            BOOT_FETCH_ADDR <= BRC_BOOT_ADDR;
            EXT_MEM_DATA_WIDTH <= BRC_BOOT_DWIDTH;
            EXT_MEM_ADDR_WIDTH <= BRC_BOOT_AWIDTH;
        end
    end

    // ------------------------------------------------------------
    // Vector window remap
    // ------------------------------------------------------------
    // Only the low window is redirected; all else passes through
    always_ff @(posedge CLK) begin
        if (RST) begin
            MAPPED_ADDR <= 32'h0000_0000;
        end else if (CE) begin
            if (CPU_ADDR < BRC_VEC_SIZE) begin
                case (map_sel)
                    BRC_MAP_BOOTROM: MAPPED_ADDR <= BRC_BOOTROM_BASE | CPU_ADDR;
                    BRC_MAP_SRAM: MAPPED_ADDR <= BRC_SRAM_BASE | CPU_ADDR;
                    BRC_MAP_EXTMEM: MAPPED_ADDR <= BRC_BOOT_ADDR | CPU_ADDR;
                    default: MAPPED_ADDR <= BRC_BOOT_ADDR | CPU_ADDR;
                endcase
            end else begin
                MAPPED_ADDR <= CPU_ADDR;
            end
        end
    end

    // ------------------------------------------------------------
    // External interrupt inputs
    // ------------------------------------------------------------
    // Edge inputs give one-cycle rising-edge pulses; level pass registered
    always_ff @(posedge CLK) begin
        if (RST || sys_rst) begin
            edge_prev <= '0;
            EDGE_EVENT <= '0;
            LEVEL_IRQ <= '0;
            warn_prev <= 1'b0;
        end else if (CE) begin
            edge_prev <= EDGE_IRQ_IN;
            EDGE_EVENT <= EDGE_IRQ_IN & ~edge_prev;
            LEVEL_IRQ <= LEVEL_IRQ_IN;
            warn_prev <= SUPPLY_WARN;
        end
    end

    // Wake only from enabled level inputs while powered down
    assign wake_hit = POWER_DOWN && |(LEVEL_IRQ_IN & wake_en);

    always_ff @(posedge CLK) begin
        if (RST || sys_rst) begin
            WAKEUP <= 1'b0;
        end else if (CE) begin
            WAKEUP <= wake_hit;
        end
    end

    // Warning level goes straight to the interrupt controller
    always_ff @(posedge CLK) begin
        if (RST || sys_rst) begin
            SDM_IRQ <= 1'b0;
        end else if (CE) begin
            SDM_IRQ <= SUPPLY_WARN;
        end
    end

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    assign AWREADY = !aw_held && !BVALID;
    assign WREADY = !w_held && !BVALID;
    assign wr_go = aw_held && w_held && !BVALID;

    // Address and data may arrive in either order
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            BVALID <= 1'b0;
            BRESP <= 2'h0;
        end else if (CE) begin
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= mapped(aw_addr) ? 2'h0 : 2'h2; // SLVERR if unmapped
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Map select defaults to external memory to match the boot source
    always_ff @(posedge CLK) begin
        if (RST) begin
            map_sel <= brc_map_t'(BRC_MAP_RESET);
            sdm_rst_en <= 1'b0;
            irq_mask <= 2'h0;
            wake_en <= '0;
        end else if (CE && sys_rst) begin
            // Every internal reset boots from external memory again, so the map follows;
            // enables survive so a brownout reset keeps holding. Writes here are dropped.
            map_sel <= brc_map_t'(BRC_MAP_RESET);
        end else if (CE && wr_go && w_strb[0]) begin
            if (hit(aw_addr, BRC_OFS_CTRL)) begin
                // Software remap after boot; reserved code is ignored
                if (w_data[BRC_CTRL_MAP_LSB+:2] != 2'h3) begin
                    map_sel <= brc_map_t'(w_data[BRC_CTRL_MAP_LSB+:2]);
                end
                sdm_rst_en <= w_data[BRC_CTRL_RSTEN_BIT];
            end
            if (hit(aw_addr, BRC_OFS_IRQ_MASK)) begin
                irq_mask <= w_data[1:0];
            end
            if (hit(aw_addr, BRC_OFS_WAKE_EN)) begin
                wake_en <= w_data[N_LEVEL-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky status, write one to clear; a new event wins
    // ------------------------------------------------------------
    assign events = {wake_hit, SUPPLY_WARN && !warn_prev};

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat <= 2'h0;
        end else if (CE) begin
            if (wr_go && w_strb[0] && hit(aw_addr, BRC_OFS_IRQ_STAT)) begin
                irq_stat <= (irq_stat & ~w_data[1:0]) | events;
            end else begin
                irq_stat <= irq_stat | events;
            end
        end
    end

    assign IRQ = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Read channel, one cycle latency
    // ------------------------------------------------------------
    assign ARREADY = !RVALID;

    always_ff @(posedge CLK) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= 2'h0;
        end else if (CE) begin
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RRESP <= mapped(ARADDR) ? 2'h0 : 2'h2;
                RDATA <= 32'h0000_0000;
                if (hit(ARADDR, BRC_OFS_CTRL)) begin
                    RDATA <= {29'h0, sdm_rst_en, map_sel};
                end else if (hit(ARADDR, BRC_OFS_STATUS)) begin
                    RDATA <= {30'h0, SUPPLY_LOW, SUPPLY_WARN};
                end else if (hit(ARADDR, BRC_OFS_IRQ_STAT)) begin
                    RDATA <= {30'h0, irq_stat};
                end else if (hit(ARADDR, BRC_OFS_IRQ_MASK)) begin
                    RDATA <= {30'h0, irq_mask};
                end else if (hit(ARADDR, BRC_OFS_WAKE_EN)) begin
                    RDATA <= 32'(wake_en);
                end else if (hit(ARADDR, BRC_OFS_BOOTCFG)) begin
                    RDATA <= {20'h0, BRC_BOOT_AWIDTH, BRC_BOOT_DWIDTH};
                end
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_boot_addr: assert property (@(posedge CLK) disable iff (RST)
        BOOT_FETCH_ADDR == BRC_BOOT_ADDR) else $error("boot fetch address wrong");
    a_boot_bus: assert property (@(posedge CLK) disable iff (RST)
        EXT_MEM_DATA_WIDTH == BRC_BOOT_DWIDTH && EXT_MEM_ADDR_WIDTH == BRC_BOOT_AWIDTH)
        else $error("boot bus width wrong");
    a_vec_ext: assert property (@(posedge CLK) disable iff (RST)
        (CE && map_sel == BRC_MAP_EXTMEM && CPU_ADDR < BRC_VEC_SIZE)
        |=> MAPPED_ADDR == (BRC_BOOT_ADDR | $past(CPU_ADDR))) else $error("vector not external");
    a_vec_sram: assert property (@(posedge CLK) disable iff (RST)
        (CE && map_sel == BRC_MAP_SRAM && CPU_ADDR < BRC_VEC_SIZE)
        |=> MAPPED_ADDR[31:24] == 8'h40) else $error("vector not in sram");
    a_warn_irq: assert property (@(posedge CLK) disable iff (RST || sys_rst)
        (CE && SUPPLY_WARN) |=> SDM_IRQ) else $error("warning not forwarded");
    a_irq_gate: assert property (@(posedge CLK) disable iff (RST)
        !irq_mask[BRC_EV_WARN_BIT] && !irq_mask[BRC_EV_WAKE_BIT] |-> !IRQ)
        else $error("masked interrupt raised");
    a_low_reset: assert property (@(posedge CLK) disable iff (RST)
        (CE && SUPPLY_LOW && sdm_rst_en) |=> CHIP_RST) else $error("no brownout reset");
    a_low_hold: assert property (@(posedge CLK) disable iff (RST)
        (CE && SUPPLY_LOW && sdm_rst_en) [*3] |=> CHIP_RST) else $error("reset dropped");
    a_edge_pulse: assert property (@(posedge CLK) disable iff (RST || sys_rst)
        (CE && $rose(EDGE_IRQ_IN[0])) |=> EDGE_EVENT[0]) else $error("edge lost");
    a_wake_forward: assert property (@(posedge CLK) disable iff (RST || sys_rst)
        (CE && wake_hit) |=> WAKEUP) else $error("wake lost");
    a_map_reset: assert property (@(posedge CLK)
        $fell(RST) |-> map_sel == BRC_MAP_EXTMEM) else $error("map reset wrong");

endmodule

/* File: tb/brc_supply_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Supply comparator pair on the far side of the block
// ------------------------------------------------------------
// Rail level is given in millivolts by the bench.
// Hysteresis is left out, so bench steps must cross thresholds cleanly.
module brc_supply_model #(
    parameter int WARN_MV = 2950, // First-stage threshold
    parameter int LOW_MV = 2650   // Second-stage threshold
) (
    input wire logic [11:0] supply_mv,
    output logic supply_warn,
    output logic supply_low
);
    // Analog comparators: outputs follow the rail with no clock
    assign supply_warn = (supply_mv < WARN_MV);
    assign supply_low = (supply_mv < LOW_MV);
endmodule

/* File: tb/test_brc_top.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Self-checking bench for the boot, map and brownout block
// ------------------------------------------------------------
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

module test_brc_top;
    import brc_pkg::*;
    localparam int HOLD = 4; // Short stretch keeps the run brief
    logic CLK, RST, CE, RESET_PIN_N, WDT_RST, POR, OSC_OK, SUPPLY_WARN, SUPPLY_LOW;
    logic [67:0] EDGE_IRQ_IN, EDGE_EVENT;
    logic [3:0] LEVEL_IRQ_IN, LEVEL_IRQ, WSTRB;
    logic POWER_DOWN, CHIP_RST, SDM_IRQ, WAKEUP, IRQ;
    logic [31:0] CPU_ADDR, MAPPED_ADDR, BOOT_FETCH_ADDR, WDATA, RDATA, rdat, a;
    logic [5:0] EXT_MEM_DATA_WIDTH, EXT_MEM_ADDR_WIDTH;
    logic [7:0] AWADDR, ARADDR;
    logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
    logic [1:0] BRESP, RRESP, rresp, bresp;
    logic [11:0] mv; // Rail level handed to the comparator model
    int miscompares, checks_done, cycles, cnt, k;
    int maps[3] = '{2, 0, 1};

    brc_supply_model brc_supply_model_i (.supply_mv(mv), .supply_warn(SUPPLY_WARN),
        .supply_low(SUPPLY_LOW));

    brc_top #(.HOLD_CYC(HOLD)) brc_top_i (.CLK(CLK), .RST(RST), .CE(CE),
        .RESET_PIN_N(RESET_PIN_N), .WDT_RST(WDT_RST), .POR(POR), .OSC_OK(OSC_OK),
        .SUPPLY_WARN(SUPPLY_WARN), .SUPPLY_LOW(SUPPLY_LOW), .EDGE_IRQ_IN(EDGE_IRQ_IN),
        .LEVEL_IRQ_IN(LEVEL_IRQ_IN), .POWER_DOWN(POWER_DOWN), .CPU_ADDR(CPU_ADDR),
        .MAPPED_ADDR(MAPPED_ADDR), .BOOT_FETCH_ADDR(BOOT_FETCH_ADDR),
        .EXT_MEM_DATA_WIDTH(EXT_MEM_DATA_WIDTH), .EXT_MEM_ADDR_WIDTH(EXT_MEM_ADDR_WIDTH),
        .CHIP_RST(CHIP_RST), .SDM_IRQ(SDM_IRQ), .EDGE_EVENT(EDGE_EVENT),
        .LEVEL_IRQ(LEVEL_IRQ), .WAKEUP(WAKEUP), .IRQ(IRQ), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

    // 200 MHz clock
    always #2.5 CLK = ~CLK;

    // Verdict and end of run
    task automatic conclude();
        if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard, well above the length of the sequence
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // Expected vector window translation
    function automatic logic [31:0] exp_map(input int m, input logic [31:0] ad);
        if (ad >= BRC_VEC_SIZE) return ad;
        case (m)
            0: return BRC_BOOTROM_BASE | ad;
            1: return BRC_SRAM_BASE | ad;
            default: return BRC_BOOT_ADDR | ad;
        endcase
    endfunction

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic ad_t, wd_t;
        ad_t = 0;
        wd_t = 0;
        @(posedge CLK);
        AWADDR <= ad;
        WDATA <= d;
        WSTRB <= 4'hF;
        AWVALID <= 1;
        WVALID <= 1;
        BREADY <= 1;
        while (!(ad_t && wd_t)) begin
            @(posedge CLK);
            if (!ad_t && AWREADY) begin
                ad_t = 1;
                AWVALID <= 0;
            end
            if (!wd_t && WREADY) begin
                wd_t = 1;
                WVALID <= 0;
            end
        end
        do @(posedge CLK); while (BVALID !== 1'b1);
        bresp = BRESP;
        BREADY <= 0;
        @(posedge CLK);
    endtask

    // Read: result lands in rdat and rresp
    task automatic rd(input logic [7:0] ad);
        @(posedge CLK);
        ARADDR <= ad;
        ARVALID <= 1;
        RREADY <= 1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 0;
        do @(posedge CLK); while (RVALID !== 1'b1);
        rdat = RDATA;
        rresp = RRESP;
        RREADY <= 0;
        @(posedge CLK);
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] e, input string n);
        rd(ad);
        `CHK(n, e, rdat)
    endtask

    // Counts cycles until internal reset drops; too short or stuck both fail
    task automatic rel(input string n);
        cnt = 0;
        while (CHIP_RST === 1'b1 && cnt < 50) begin
            @(negedge CLK);
            cnt++;
        end
        `CHK(n, 1'b1, (cnt >= HOLD && cnt <= HOLD + 3))
    endtask

    // Present one CPU address, look one cycle later
    task automatic xlat(input logic [31:0] ad);
        @(posedge CLK);
        CPU_ADDR <= ad;
        @(posedge CLK);
        @(negedge CLK);
    endtask

    initial begin
        void'($urandom(65177));
        {CLK, CE, RST, RESET_PIN_N, OSC_OK, WDT_RST, POR, POWER_DOWN} = 8'b0111_1000;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
        {EDGE_IRQ_IN, LEVEL_IRQ_IN, CPU_ADDR, AWADDR, ARADDR, WDATA, WSTRB} = '0;
        {miscompares, checks_done, cycles} = '0;
        mv = 12'd3300;
        repeat (5) @(posedge CLK);
        RST <= 0;
        rel("reset release");
        `CHK("fetch addr", 32'h8100_0000, BOOT_FETCH_ADDR)
        `CHK("data width", 6'h10, EXT_MEM_DATA_WIDTH)
        `CHK("addr width", 6'h18, EXT_MEM_ADDR_WIDTH)
        rdchk(BRC_OFS_BOOTCFG, 32'h0000_0610, "bootcfg");
        rdchk(BRC_OFS_CTRL, 32'h0000_0002, "ctrl reset");
        // Reset map first, then software remaps; last try lies outside the window
        for (int i = 0; i < 3; i++) begin
            if (i > 0) wr(BRC_OFS_CTRL, maps[i]);
            for (int j = 0; j < 4; j++) begin
                a = (j < 3) ? ($urandom & 32'h3C) : (32'h1000 | ($urandom & 32'h0FFF_FFFC));
                xlat(a);
                `CHK("mapped addr", exp_map(maps[i], a), MAPPED_ADDR)
            end
        end
        wr(BRC_OFS_CTRL, 32'h0000_0003);
        `CHK("write resp", 2'b00, bresp)
        rdchk(BRC_OFS_CTRL, 32'h0000_0001, "map code 3");
        rdchk(8'h40, 32'h0, "unmapped data");
        `CHK("unmapped resp", 2'b10, rresp)
        wr(8'h40, 32'h0);
        `CHK("unmapped wresp", 2'b10, bresp)
        // Warning band: request raised, CPU interrupt only once enabled
        wr(BRC_OFS_IRQ_MASK, 32'h0);
        mv <= 12'($urandom_range(2949, 2651));
        repeat (3) @(negedge CLK);
        `CHK("warn request", 1'b1, SDM_IRQ)
        `CHK("irq masked", 1'b0, IRQ)
        rdchk(BRC_OFS_STATUS, 32'h1, "status warn");
        rdchk(BRC_OFS_IRQ_STAT, 32'h1, "stat warn");
        wr(BRC_OFS_IRQ_MASK, 32'h1);
        @(negedge CLK);
        `CHK("irq enabled", 1'b1, IRQ)
        // Deep drop with the reset source disabled: no chip reset
        @(posedge CLK);
        mv <= 12'd2600;
        repeat (5) @(negedge CLK);
        `CHK("low no reset", 1'b0, CHIP_RST)
        rdchk(BRC_OFS_STATUS, 32'h3, "status low");
        @(posedge CLK);
        mv <= 12'd3300;
        wr(BRC_OFS_IRQ_STAT, 32'h1);
        @(negedge CLK);
        `CHK("irq cleared", 1'b0, IRQ)
        // Wake from power-down only through an enabled level input
        wr(BRC_OFS_WAKE_EN, 32'h1);
        @(posedge CLK);
        POWER_DOWN <= 1;
        LEVEL_IRQ_IN <= 4'h2;
        repeat (3) @(negedge CLK);
        `CHK("wake masked", 1'b0, WAKEUP)
        `CHK("level copy", 4'h2, LEVEL_IRQ)
        @(posedge CLK);
        LEVEL_IRQ_IN <= 4'h1;
        repeat (3) @(negedge CLK);
        `CHK("wake", 1'b1, WAKEUP)
        @(posedge CLK);
        POWER_DOWN <= 0;
        LEVEL_IRQ_IN <= 4'h0;
        rdchk(BRC_OFS_IRQ_STAT, 32'h2, "stat wake");
        // Clock enable low freezes the registered copies
        CE <= 0;
        LEVEL_IRQ_IN <= 4'h5;
        repeat (3) @(negedge CLK);
        `CHK("frozen copy", 4'h0, LEVEL_IRQ)
        @(posedge CLK);
        CE <= 1;
        LEVEL_IRQ_IN <= 4'h0;
        // One rising edge gives exactly one pulse on its own bit; bit 0 first
        for (int e = 0; e < 2; e++) begin
            k = (e == 0) ? 0 : $urandom_range(67, 1);
            @(posedge CLK);
            EDGE_IRQ_IN <= 68'(1) << k;
            cnt = 0;
            repeat (5) begin
                @(negedge CLK);
                if (EDGE_EVENT === 68'(1) << k) cnt++;
            end
            `CHK("edge pulse", 1, cnt)
            @(posedge CLK);
            EDGE_IRQ_IN <= '0;
        end
        // Each reset source in turn; the last is the deep brownout
        for (int i = 0; i < 5; i++) begin
            if (i == 4) wr(BRC_OFS_CTRL, 32'h0000_0006);
            @(posedge CLK);
            case (i)
                0: RESET_PIN_N <= 0;
                1: WDT_RST <= 1;
                2: POR <= 1;
                3: OSC_OK <= 0;
                default: mv <= 12'd2600;
            endcase
            repeat (6) @(negedge CLK);
            `CHK("reset held", 1'b1, CHIP_RST)
            @(posedge CLK);
            {RESET_PIN_N, WDT_RST, POR, OSC_OK} <= 4'b1001;
            mv <= 12'd3300;
            rel("source release");
            if (i == 0) rdchk(BRC_OFS_CTRL, 32'h2, "map after reset");
        end
        conclude();
    end
endmodule
